// ### hw/sleep_entry_wake_counter.sv
// sleep entry and main oscillator start-up counter with Avalon-MM registers
// assumes a single-master Avalon-MM bus on ref_clk_i with byte addresses,
// an asynchronous wake pin and two asynchronous slow sleep clock pins
//
// Our own choice: the Avalon-MM slave port.
`timescale 1ns/1ns
`default_nettype none
`include "sleep_wake_consts.svh"

// Functional notes
// - A 9-bit start-up count sets the warm-up time of the 20 MHz oscillator after wake.
// - Count bits 6..0 sit in the sleep/wake register, bits 8..7 in rf_mode_control bits 4..3.
// - One count unit is one period of the slow sleep clock.
// - The count resets to 0x00; software should program 0x05F.
// - The sleep clock period comes from a 2-bit source select and a 5-bit divisor.
module sleep_entry_wake_counter
    import sleep_wake_pkg::*;
#(
    parameter int ADDR_W  = 10,
    parameter int COUNT_W = 9,
    parameter int DIV_W   = 5
) (
    input  wire logic              ref_clk_i,
    input  wire logic              rst_i,
    input  wire logic [ADDR_W-1:0] avs_address_i,
    input  wire logic              avs_read_i,
    input  wire logic              avs_write_i,
    input  wire logic [31:0]       avs_writedata_i,
    input  wire logic [3:0]        avs_byteenable_i,
    output logic      [31:0]       avs_readdata_o,
    output logic                   avs_waitrequest_o,
    input  wire logic              wake_pin_i,
    input  wire logic              sleep_clk_int_i,
    input  wire logic              sleep_clk_ext_i,
    output logic                   sleep_mode_o,
    output logic                   osc_enable_o,
    output logic                   osc_clk_release_o,
    output logic                   core_hold_o
);

    ////////////////////////////////////////////////////////////////////////
    // declarations

    logic [31:0]        rdata_q;
    logic [31:0]        rdata_d;
    logic               wait_q;
    logic               wait_d;
    logic               bus_req;
    logic               bus_commit;
    logic               wr_commit;
    logic [7:0]         word_idx;
    logic [7:0]         wbyte;
    logic [7:0]         rd_byte;

    logic [COUNT_W-1:0] wake_count_q;
    logic [COUNT_W-1:0] wake_count_d;
    logic [2:0]         rf_mode_low_q;
    logic [2:0]         rf_mode_low_d;
    logic [1:0]         clk_sel_q;
    logic [1:0]         clk_sel_d;
    logic [DIV_W-1:0]   clk_div_q;
    logic [DIV_W-1:0]   clk_div_d;
    logic               sleep_req_q;
    logic               sleep_req_d;

    logic [1:0]         wake_sync_q;
    logic [1:0]         wake_sync_d;
    power_state_e       state_q;
    power_state_e       state_d;
    logic [COUNT_W-1:0] warm_cnt_q;
    logic [COUNT_W-1:0] warm_cnt_d;
    logic               sleep_mode_q;
    logic               sleep_mode_d;
    logic               osc_en_q;
    logic               osc_en_d;
    logic               release_q;
    logic               release_d;
    logic               hold_q;
    logic               hold_d;
    logic               sleep_tick;

    ////////////////////////////////////////////////////////////////////////
    // sleep clock tick source

    // free-running divider: the first tick of a warm-up may come early
    sleep_tick_gen #(
        .DIV_W (DIV_W)
    ) u_tick (
        .ref_clk_i (ref_clk_i),
        .rst_i     (rst_i),
        .clk_int_i (sleep_clk_int_i),
        .clk_ext_i (sleep_clk_ext_i),
        .select_i  (clk_sel_q),
        .divisor_i (clk_div_q),
        .tick_o    (sleep_tick)
    );

    ////////////////////////////////////////////////////////////////////////
    // request decode: only byte lane 0 carries a register

    always_comb begin
        bus_req    = avs_read_i || avs_write_i;
        bus_commit = bus_req && !wait_q;
        wr_commit  = bus_commit && avs_write_i && avs_byteenable_i[0];
        word_idx   = avs_address_i[9:2];
        wbyte      = avs_writedata_i[7:0];
    end

    ////////////////////////////////////////////////////////////////////////
    // read data byte, unmapped indices read as zero

    always_comb begin
        rd_byte = 8'h00;
        unique case (word_idx)
            `IDX_SLEEP_ACK_WAKE_COUNT: begin
                // top bit always reads back cleared
                rd_byte[`WAKE_LOW_MSB:0] = wake_count_q[6:0];
            end
            `IDX_RF_MODE_CONTROL: begin
                rd_byte[`WAKE_HIGH_MSB:`WAKE_HIGH_LSB] = wake_count_q[8:7];
                rd_byte[`RF_MODE_LOW_MSB:0] = rf_mode_low_q;
            end
            `IDX_SLEEP_CLOCK_SELECT: begin
                rd_byte[`SEL_MSB:`SEL_LSB] = clk_sel_q;
            end
            `IDX_SLEEP_CLOCK_DIVISOR: begin
                rd_byte[`DIV_MSB:0] = clk_div_q;
            end
            `IDX_SLEEP_STATUS: begin
                rd_byte[1:0] = state_q;
                rd_byte[2]   = release_q;
                rd_byte[3]   = hold_q;
            end
            default: begin
                rd_byte = 8'h00;
            end
        endcase
    end

    ////////////////////////////////////////////////////////////////////////
    // bus slave: one wait cycle, then waitrequest low for exactly one cycle

    always_comb begin
        wait_d  = 1'b1;
        rdata_d = rdata_q;
        if (bus_req && wait_q) begin
            wait_d  = 1'b0;
            rdata_d = 32'h0000_0000;
            if (avs_read_i) begin
                rdata_d[7:0] = rd_byte;
            end
        end
    end

    always_ff @(posedge ref_clk_i or posedge rst_i) begin
        if (rst_i) begin
            wait_q  <= 1'b1;
            rdata_q <= 32'h0000_0000;
        end else begin
            wait_q  <= wait_d;
            rdata_q <= rdata_d;
        end
    end

    assign avs_waitrequest_o = wait_q;
    assign avs_readdata_o    = rdata_q;

    ////////////////////////////////////////////////////////////////////////
    // registers written by software

    always_comb begin
        wake_count_d  = wake_count_q;
        rf_mode_low_d = rf_mode_low_q;
        clk_sel_d     = clk_sel_q;
        clk_div_d     = clk_div_q;
        sleep_req_d   = 1'b0;
        if (wr_commit) begin
            unique case (word_idx)
                `IDX_SLEEP_ACK_WAKE_COUNT: begin
                    wake_count_d[6:0] = wbyte[`WAKE_LOW_MSB:0];
                    sleep_req_d       = wbyte[`SLEEP_REQUEST_BIT];
                end
                `IDX_RF_MODE_CONTROL: begin
                    wake_count_d[8:7] = wbyte[`WAKE_HIGH_MSB:`WAKE_HIGH_LSB];
                    rf_mode_low_d     = wbyte[`RF_MODE_LOW_MSB:0];
                end
                `IDX_SLEEP_CLOCK_SELECT: begin
                    clk_sel_d = wbyte[`SEL_MSB:`SEL_LSB];
                end
                `IDX_SLEEP_CLOCK_DIVISOR: begin
                    clk_div_d = wbyte[`DIV_MSB:0];
                end
                default: begin
                    wake_count_d = wake_count_q;
                end
            endcase
        end
    end

    always_ff @(posedge ref_clk_i or posedge rst_i) begin
        if (rst_i) begin
            wake_count_q  <= `WAKE_COUNT_RESET;
            rf_mode_low_q <= `RF_MODE_RESET;
            clk_sel_q     <= `SEL_RESET;
            clk_div_q     <= `DIV_RESET;
            sleep_req_q   <= 1'b0;
        end else begin
            wake_count_q  <= wake_count_d;
            rf_mode_low_q <= rf_mode_low_d;
            clk_sel_q     <= clk_sel_d;
            clk_div_q     <= clk_div_d;
            sleep_req_q   <= sleep_req_d;
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // wake pin synchroniser

    always_comb begin
        wake_sync_d = {wake_sync_q[0], wake_pin_i};
    end

    always_ff @(posedge ref_clk_i or posedge rst_i) begin
        if (rst_i) begin
            wake_sync_q <= 2'h0;
        end else begin
            wake_sync_q <= wake_sync_d;
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // power state machine and oscillator start-up timer

    always_comb begin
        state_d      = state_q;
        warm_cnt_d   = warm_cnt_q;
        unique case (state_q)
            ST_ACTIVE: begin
                if (sleep_req_q) begin
                    state_d = ST_SLEEP;
                end
            end
            ST_SLEEP: begin
                if (wake_sync_q[1]) begin
                    state_d    = ST_WARMUP;
                    warm_cnt_d = '0;
                end
            end
            ST_WARMUP: begin
                // count is read live: a rewrite during warm-up applies at once
                if (warm_cnt_q >= wake_count_q) begin
                    state_d = ST_ACTIVE;
                end else if (sleep_tick) begin
                    warm_cnt_d = warm_cnt_q + COUNT_W'(1);
                end
            end
            default: begin
                state_d = ST_ACTIVE;
            end
        endcase
        // safe default: oscillator off, core held
        sleep_mode_d = 1'b0;
        osc_en_d     = 1'b0;
        release_d    = 1'b0;
        hold_d       = 1'b1;
        unique case (state_d)
            ST_ACTIVE: begin
                osc_en_d  = 1'b1;
                release_d = 1'b1;
                hold_d    = 1'b0;
            end
            ST_SLEEP: begin
                sleep_mode_d = 1'b1;
            end
            ST_WARMUP: begin
                osc_en_d = 1'b1;
            end
        endcase
    end

    always_ff @(posedge ref_clk_i or posedge rst_i) begin
        if (rst_i) begin
            state_q      <= ST_ACTIVE;
            warm_cnt_q   <= '0;
            sleep_mode_q <= 1'b0;
            osc_en_q     <= 1'b1;
            release_q    <= 1'b1;
            hold_q       <= 1'b0;
        end else begin
            state_q      <= state_d;
            warm_cnt_q   <= warm_cnt_d;
            sleep_mode_q <= sleep_mode_d;
            osc_en_q     <= osc_en_d;
            release_q    <= release_d;
            hold_q       <= hold_d;
        end
    end

    assign sleep_mode_o      = sleep_mode_q;
    assign osc_enable_o      = osc_en_q;
    assign osc_clk_release_o = release_q;
    assign core_hold_o       = hold_q;

endmodule
`default_nettype wire

// ### hw/sleep_tick_gen.sv
// sleep clock tick generator: picks one of two slow clock pins, divides it
// assumes both pins are asynchronous to ref_clk_i and far slower than it
`timescale 1ns/1ns
`default_nettype none
`include "sleep_wake_consts.svh"

module sleep_tick_gen #(
    parameter int DIV_W = 5
) (
    input  wire logic             ref_clk_i,
    input  wire logic             rst_i,
    input  wire logic             clk_int_i,
    input  wire logic             clk_ext_i,
    input  wire logic [1:0]       select_i,
    input  wire logic [DIV_W-1:0] divisor_i,
    output logic                  tick_o
);

    logic [1:0]       int_sync_q;
    logic [1:0]       ext_sync_q;
    logic             src_prev_q;
    logic             src_prev_d;
    logic [DIV_W-1:0] div_cnt_q;
    logic [DIV_W-1:0] div_cnt_d;
    logic             tick_q;
    logic             tick_d;
    logic             src_now;
    logic [DIV_W-1:0] div_limit;

    ////////////////////////////////////////////////////////////////////////
    // two-stage synchronisers, second stage is the only reader of the first
    always_ff @(posedge ref_clk_i or posedge rst_i) begin
        if (rst_i) begin
            int_sync_q <= 2'h0;
            ext_sync_q <= 2'h0;
        end else begin
            int_sync_q <= {int_sync_q[0], clk_int_i};
            ext_sync_q <= {ext_sync_q[0], clk_ext_i};
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // one tick per divisor rising source edges, divisor 0 acts as 1
    always_comb begin
        src_now    = (select_i == `SEL_EXTERNAL) ? ext_sync_q[1] : int_sync_q[1];
        div_limit  = (divisor_i == '0) ? DIV_W'(1) : divisor_i;
        src_prev_d = src_now;
        div_cnt_d  = div_cnt_q;
        tick_d     = 1'b0;
        if (src_now && !src_prev_q) begin
            if (div_cnt_q + DIV_W'(1) >= div_limit) begin
                div_cnt_d = '0;
                tick_d    = 1'b1;
            end else begin
                div_cnt_d = div_cnt_q + DIV_W'(1);
            end
        end
    end

    always_ff @(posedge ref_clk_i or posedge rst_i) begin
        if (rst_i) begin
            src_prev_q <= 1'b0;
            div_cnt_q  <= '0;
            tick_q     <= 1'b0;
        end else begin
            src_prev_q <= src_prev_d;
            div_cnt_q  <= div_cnt_d;
            tick_q     <= tick_d;
        end
    end

    assign tick_o = tick_q;

endmodule
`default_nettype wire

// ### hw/sleep_wake_consts.svh
// register indices, field positions, reset values and counts for the
// sleep entry and wake counter block; definitions only
`ifndef SLEEP_WAKE_CONSTS_SVH
`define SLEEP_WAKE_CONSTS_SVH

// register indices, byte address is four times the index
`define IDX_SLEEP_ACK_WAKE_COUNT 8'h35
`define IDX_RF_MODE_CONTROL      8'h36
`define IDX_SLEEP_CLOCK_SELECT   8'h38
`define IDX_SLEEP_CLOCK_DIVISOR  8'h39
`define IDX_SLEEP_STATUS         8'h3A

// field positions
`define SLEEP_REQUEST_BIT        7
`define WAKE_LOW_MSB             6
`define WAKE_HIGH_MSB            4
`define WAKE_HIGH_LSB            3
`define RF_MODE_LOW_MSB          2
`define SEL_MSB                  7
`define SEL_LSB                  6
`define DIV_MSB                  4

// reset and advisory values
`define WAKE_COUNT_RESET         9'h000
`define WAKE_COUNT_ADVISED       9'h05F
`define RF_MODE_RESET            3'h0
`define SEL_RESET                2'h0
`define DIV_RESET                5'h00

// sleep clock source codes
`define SEL_EXTERNAL             2'h1

`endif

// ### hw/sleep_wake_pkg.sv
// types shared by the sleep entry and wake counter block
package sleep_wake_pkg;

    typedef enum logic [1:0] {
        ST_ACTIVE = 2'b00,
        ST_SLEEP  = 2'b01,
        ST_WARMUP = 2'b10
    } power_state_e;

endpackage

// ### testbench/sleep_entry_wake_counter_sva.sv
// assertion checker for the sleep entry and wake counter block
// sees only the top module's ports; bound from the testbench top file
`timescale 1ns/1ns
`default_nettype none
`include "sleep_wake_consts.svh"
module sleep_entry_wake_counter_sva #(
    parameter int ADDR_W = 10
) (
    input wire logic              ref_clk_i,
    input wire logic              rst_i,
    input wire logic [ADDR_W-1:0] avs_address_i,
    input wire logic              avs_read_i,
    input wire logic              avs_write_i,
    input wire logic [31:0]       avs_writedata_i,
    input wire logic [3:0]        avs_byteenable_i,
    input wire logic [31:0]       avs_readdata_o,
    input wire logic              avs_waitrequest_o,
    input wire logic              wake_pin_i,
    input wire logic              sleep_clk_int_i,
    input wire logic              sleep_clk_ext_i,
    input wire logic              sleep_mode_o,
    input wire logic              osc_enable_o,
    input wire logic              osc_clk_release_o,
    input wire logic              core_hold_o
);
    default clocking cb @(posedge ref_clk_i); endclocking
    default disable iff (rst_i);
    wire logic [7:0] idx = avs_address_i[9:2];
    wire logic       ack = !avs_waitrequest_o;
    wire logic       mapped = idx inside {8'h35, 8'h36, 8'h38, 8'h39, 8'h3A};
    // committed write of 1 to the sleep request bit
    wire logic       sleep_cmd = avs_write_i && ack && idx == `IDX_SLEEP_ACK_WAKE_COUNT
                                 && avs_byteenable_i[0] && avs_writedata_i[`SLEEP_REQUEST_BIT];

    AST_WAIT_ONE: assert property ((avs_read_i || avs_write_i) && avs_waitrequest_o |=> ack)
        else $error("waitrequest did not drop one cycle after a request");
    AST_WAIT_PULSE: assert property (ack |=> avs_waitrequest_o)
        else $error("waitrequest low for more than one cycle");
    AST_UNMAPPED: assert property (ack && avs_read_i && !mapped |-> avs_readdata_o == 32'h0)
        else $error("unmapped read returned nonzero data");
    AST_SLEEP_ENTRY: assert property (
        sleep_cmd && osc_clk_release_o |-> ##2 sleep_mode_o && !osc_enable_o && core_hold_o)
        else $error("sleep not entered two cycles after the request");
    AST_SLEEP_CAUSE: assert property ($rose(sleep_mode_o) |-> $past(sleep_cmd, 2))
        else $error("sleep entered without a request");
    AST_SLEEP_BIT_CLEAR: assert property (
        ack && avs_read_i && idx == `IDX_SLEEP_ACK_WAKE_COUNT |-> !avs_readdata_o[7])
        else $error("sleep request bit read back as 1");
    AST_RF_RESERVED: assert property (
        ack && avs_read_i && idx == `IDX_RF_MODE_CONTROL |-> avs_readdata_o[7:5] == 3'h0)
        else $error("reserved rf mode bits read nonzero");
    AST_OSC_OFF: assert property (osc_enable_o == !sleep_mode_o)
        else $error("oscillator enable disagrees with sleep state");
    AST_HOLD_INV: assert property (core_hold_o == !osc_clk_release_o)
        else $error("core hold is not the inverse of clock release");
    AST_RELEASE_LATE: assert property (
        $rose(osc_clk_release_o) |-> $past(osc_enable_o) && !$past(sleep_mode_o))
        else $error("clock released before the oscillator ran");
endmodule
`default_nettype wire

// ### testbench/tb_sleep_entry_wake_counter.sv
// self-checking testbench for the sleep entry and wake counter block
// drives the Avalon-MM side, the wake pin and both slow sleep clocks
`timescale 1ns/1ns
`default_nettype none
`include "sleep_wake_consts.svh"
`define CHK(nm, e, g) begin checked++; if ((g) !== (e)) begin errors++; \
    $display("[ERR] %s exp %0h got %0h", nm, e, g); end end
module tb_sleep_entry_wake_counter;
    logic        clk, rst, rd, wr, wreq, wake, sci, sce, slp, oen, rel, hold;
    logic [9:0]  adr;
    logic [31:0] wd, rdat;
    logic [3:0]  be, ce;
    logic [2:0]  ci;
    int          errors, checked;

    sleep_entry_wake_counter uut (
        .ref_clk_i(clk), .rst_i(rst), .avs_address_i(adr), .avs_read_i(rd),
        .avs_write_i(wr), .avs_writedata_i(wd), .avs_byteenable_i(be),
        .avs_readdata_o(rdat), .avs_waitrequest_o(wreq), .wake_pin_i(wake),
        .sleep_clk_int_i(sci), .sleep_clk_ext_i(sce), .sleep_mode_o(slp),
        .osc_enable_o(oen), .osc_clk_release_o(rel), .core_hold_o(hold)
    );
    ////////////////////////////////////////////////////////////////////////////
    // free-running sleep clocks: internal 8 cycles, external 12 cycles
    always @(posedge clk) begin
        ci <= ci + 3'h1;
        ce <= (ce == 4'hB) ? 4'h0 : ce + 4'h1;
        sci <= ci[2];
        sce <= (ce < 4'h6);
    end
    ////////////////////////////////////////////////////////////////////////////
    task automatic bus(input logic w, input logic [7:0] ix, input logic [7:0] d,
                       input logic [3:0] b, output logic [7:0] q);
        int n;
        @(posedge clk);
        adr <= {ix, 2'b00};
        wd <= {24'h0, d};
        be <= b;
        wr <= w;
        rd <= !w;
        n = 0;
        do begin
            @(posedge clk);
            n++;
        end while (wreq !== 1'b0 && n < 20);
        `CHK("waitrequest", 1'b0, wreq)
        if (!w) `CHK("readdata upper", 24'h0, rdat[31:8])
        q = rdat[7:0];
        wr <= 1'b0;
        rd <= 1'b0;
    endtask
    task automatic put(input logic [7:0] ix, input logic [7:0] d);
        logic [7:0] q;
        bus(1'b1, ix, d, 4'h1, q);
    endtask
    task automatic get(input logic [7:0] ix, input logic [7:0] e);
        logic [7:0] q;
        bus(1'b0, ix, 8'h00, 4'h1, q);
        `CHK("readback", e, q)
    endtask
    // sleep_mode, osc_enable, release, hold
    task automatic pins(input logic [3:0] e);
        `CHK("power pins", e, {slp, oen, rel, hold})
    endtask
    task automatic report_and_stop;
        if (errors == 0 && checked > 0) begin
            $display("Run complete: PASS");
        end else begin
            $display("Run complete: FAIL");
        end
        $finish;
    endtask
    ////////////////////////////////////////////////////////////////////////////
    task automatic t_reset_regs;
        pins(4'b0110);
        get(8'h35, 8'h00);
        get(8'h36, 8'h00);
        get(8'h38, 8'h00);
        get(8'h39, 8'h00);
        get(8'h3A, 8'h04);
    endtask
    task automatic t_reg_access;
        logic [7:0] q;
        put(8'h35, 8'h5F);
        get(8'h35, 8'h5F);
        bus(1'b1, 8'h35, 8'h11, 4'h0, q);
        get(8'h35, 8'h5F);
        put(8'h36, 8'hFF);
        get(8'h36, 8'h1F);
        put(8'h38, 8'hFF);
        get(8'h38, 8'hC0);
        put(8'h39, 8'hFF);
        get(8'h39, 8'h1F);
        put(8'h37, 8'hA5);
        get(8'h37, 8'h00);
        put(8'h3A, 8'hFF);
        get(8'h3A, 8'h04);
    endtask
    // sleep, wake, then time the warm-up from oscillator start to release
    task automatic t_sleep_wake(input logic [1:0] sel, input logic [4:0] dv,
                                input logic [8:0] cnt);
        int p, n;
        p = ((sel == 2'h1) ? 12 : 8) * ((dv == 5'h0) ? 1 : int'(dv));
        put(8'h38, {sel, 6'h00});
        put(8'h39, {3'h0, dv});
        put(8'h36, {3'h0, cnt[8:7], 3'h0});
        put(8'h35, {1'b1, cnt[6:0]});
        repeat (3) @(posedge clk);
        pins(4'b1001);
        get(8'h35, {1'b0, cnt[6:0]});
        get(8'h3A, 8'h09);
        wake <= 1'b1;
        n = 0;
        while (oen !== 1'b1 && n < 20) begin
            @(posedge clk);
            n++;
        end
        `CHK("wake latency", 4, n)
        pins(4'b0101);
        n = 0;
        do begin
            @(posedge clk);
            n++;
        end while (rel !== 1'b1 && n < 3000);
        if (cnt == 9'h0) begin
            `CHK("warm-up cycles", 1, n)
        end else begin
            `CHK("warm-up floor", 1'b1, n >= (cnt - 1) * p)
            `CHK("warm-up ceiling", 1'b1, n <= cnt * p + 10)
        end
        pins(4'b0110);
        wake <= 1'b0;
    endtask
    task automatic t_mid_reset;
        put(8'h35, 8'hDF);
        repeat (3) @(posedge clk);
        pins(4'b1001);
        rst <= 1'b1;
        repeat (2) @(posedge clk);
        rst <= 1'b0;
        pins(4'b0110);
        @(posedge clk);
        pins(4'b0110);
        get(8'h35, 8'h00);
        get(8'h3A, 8'h04);
    endtask
    ////////////////////////////////////////////////////////////////////////////
    initial begin
        clk = 1'b0;
        forever #5 clk = ~clk;
    end
    initial begin
        rst = 1'b1;
        rd = 1'b0;
        wr = 1'b0;
        adr = 10'h000;
        wd = 32'h0;
        be = 4'h0;
        wake = 1'b0;
        sci = 1'b0;
        sce = 1'b0;
        ci = 3'h0;
        ce = 4'h0;
        repeat (5) @(posedge clk);
        rst <= 1'b0;
        t_reset_regs();
        t_reg_access();
        t_sleep_wake(2'h0, 5'h00, 9'h000);
        t_sleep_wake(2'h1, 5'h01, 9'h004);
        t_sleep_wake(2'h2, 5'h02, 9'h003);
        t_sleep_wake(2'h3, 5'h01, 9'h081);
        t_mid_reset();
        report_and_stop();
    end
    initial begin
        repeat (20000) @(posedge clk);
        errors++;
        report_and_stop();
    end
endmodule

bind sleep_entry_wake_counter sleep_entry_wake_counter_sva #(.ADDR_W(ADDR_W)) sva (
    .ref_clk_i(ref_clk_i), .rst_i(rst_i), .avs_address_i(avs_address_i),
    .avs_read_i(avs_read_i), .avs_write_i(avs_write_i), .avs_writedata_i(avs_writedata_i),
    .avs_byteenable_i(avs_byteenable_i), .avs_readdata_o(avs_readdata_o),
    .avs_waitrequest_o(avs_waitrequest_o), .wake_pin_i(wake_pin_i),
    .sleep_clk_int_i(sleep_clk_int_i), .sleep_clk_ext_i(sleep_clk_ext_i),
    .sleep_mode_o(sleep_mode_o), .osc_enable_o(osc_enable_o),
    .osc_clk_release_o(osc_clk_release_o), .core_hold_o(core_hold_o)
);
`default_nettype wire
